/* File: bench/rtcw_top_assertions.sv */
// Port-level assertions for the timer and clock watch block
`timescale 1ns/1ps
`default_nettype none
module rtcw_top_assertions (
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_timer_ctrl_wr,
  input wire logic                 i_first_reload_wr,
  input wire logic                 i_irq_clear_wr,
  input wire rtcw_pkg::rtcw_irq_t  i_irq_clear,
  input wire rtcw_pkg::rtcw_irq_t  i_irq_mask,
  input wire logic                 i_one_hertz_tick,
  input wire rtcw_pkg::rtcw_date_s i_date_time_alarm,
  input wire logic [31:0]          o_timer_count_value,
  input wire logic [31:0]          o_first_reload_value,
  input wire logic                 o_timer_run_enable,
  input wire logic [6:0]           o_pattern_index,
  input wire rtcw_pkg::rtcw_date_s o_date_time_count,
  input wire rtcw_pkg::rtcw_irq_t  o_raw_irq_status,
  input wire rtcw_pkg::rtcw_irq_t  o_masked_irq_status,
  input wire logic                 o_combined_irq
);
  import rtcw_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Loads and the zero step are excluded, so only plain decrements are seen here
  property p_step;
    o_timer_run_enable && $past(o_timer_run_enable) && !$past(i_timer_ctrl_wr) && !$past(i_first_reload_wr)
      && $past(o_timer_count_value) != 32'h0 && $changed(o_timer_count_value)
      |-> o_timer_count_value == $past(o_timer_count_value) - 32'h1;
  endproperty
  property p_src;
    $rose(o_raw_irq_status[0]) |-> $past(o_timer_count_value) == 32'h0 || $past(o_timer_count_value, 2) == 32'h0;
  endproperty
  property p_t_hold;
    o_raw_irq_status[0] && !(i_irq_clear_wr && i_irq_clear[0]) |=> o_raw_irq_status[0];
  endproperty
  property p_a_hold;
    o_raw_irq_status[1] && !(i_irq_clear_wr && i_irq_clear[1]) |=> o_raw_irq_status[1];
  endproperty
  property p_t_clr;
    i_irq_clear_wr && i_irq_clear[0] && o_raw_irq_status[0] && !o_timer_run_enable |=> !o_raw_irq_status[0];
  endproperty
  property p_mask;
    o_masked_irq_status == (o_raw_irq_status & $past(i_irq_mask));
  endproperty
  property p_comb;
    o_combined_irq == (|o_masked_irq_status);
  endproperty
  property p_halt;
    !o_timer_run_enable && !i_timer_ctrl_wr && !i_first_reload_wr |=> $stable(o_timer_count_value);
  endproperty
  property p_idx;
    $changed(o_pattern_index) |-> $past(o_timer_count_value) == 32'h0 || $past(i_timer_ctrl_wr);
  endproperty
  property p_keep;
    o_timer_run_enable && i_first_reload_wr |=> $stable(o_first_reload_value);
  endproperty
  property p_tick;
    $changed(o_date_time_count) |-> $past(i_one_hertz_tick);
  endproperty
  property p_bad_alarm;
    $rose(o_raw_irq_status[1]) |-> $past(i_date_time_alarm.second) < 6'h3C && $past(i_date_time_alarm.hour) < 5'h18;
  endproperty
  a_step: assert property (p_step) else $error("count step wrong");
  a_src: assert property (p_src) else $error("timer flag without zero");
  a_t_hold: assert property (p_t_hold) else $error("timer flag dropped");
  a_a_hold: assert property (p_a_hold) else $error("alarm flag dropped");
  a_t_clr: assert property (p_t_clr) else $error("timer clear failed");
  a_mask: assert property (p_mask) else $error("masked status wrong");
  a_comb: assert property (p_comb) else $error("combined line wrong");
  a_halt: assert property (p_halt) else $error("halted count moved");
  a_idx: assert property (p_idx) else $error("pattern index moved");
  a_keep: assert property (p_keep) else $error("reload changed while running");
  a_tick: assert property (p_tick) else $error("date moved without tick");
  a_bad_alarm: assert property (p_bad_alarm) else $error("invalid alarm matched");
  c_timer: cover property ($rose(o_raw_irq_status[0]));
  c_alarm: cover property ($rose(o_raw_irq_status[1]));
  c_comb: cover property ($rose(o_combined_irq));
endmodule
bind rtcw_top rtcw_top_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_timer_ctrl_wr(i_timer_ctrl_wr),
  .i_first_reload_wr(i_first_reload_wr), .i_irq_clear_wr(i_irq_clear_wr), .i_irq_clear(i_irq_clear),
  .i_irq_mask(i_irq_mask), .i_one_hertz_tick(i_one_hertz_tick), .i_date_time_alarm(i_date_time_alarm),
  .o_timer_count_value(o_timer_count_value), .o_first_reload_value(o_first_reload_value),
  .o_timer_run_enable(o_timer_run_enable), .o_pattern_index(o_pattern_index), .o_date_time_count(o_date_time_count),
  .o_raw_irq_status(o_raw_irq_status), .o_masked_irq_status(o_masked_irq_status), .o_combined_irq(o_combined_irq));
`default_nettype wire

/* File: bench/rtcw_top_tb.sv */
// Self-checking bench for the timer and clock watch block
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_cfg.svh"
module rtcw_top_tb;
  import rtcw_pkg::*;
  typedef struct packed {
    rtcw_date_s pre;
    rtcw_year_t pre_y;
    rtcw_date_s exp;
    rtcw_year_t exp_y;
  } rtcw_row_s;
  logic             i_ref_clk, i_rst_n, i_one_hertz_tick, o_timer_run_enable, o_combined_irq;
  logic [5:0]       wr_v;
  rtcw_timer_ctrl_s i_timer_ctrl;
  logic [31:0]      i_reload_data, o_timer_count_value, o_first_reload_value, o_second_reload_value;
  logic [127:0]     i_pattern;
  logic [6:0]       o_pattern_index;
  rtcw_date_s       i_date_time_preset, i_date_time_alarm, o_date_time_count;
  rtcw_year_t       i_year_preset, i_year_alarm, o_year_count;
  rtcw_irq_t        i_irq_clear, i_irq_mask, o_raw_irq_status, o_masked_irq_status;
  int               failures, checks, n;
  rtcw_row_s        rows [8];
  logic [31:0]      rl [3] = '{32'h1, 32'h2, 32'h1};
  logic [31:0]      ix [3] = '{32'h1, 32'h0, 32'h1};
  int               st [3] = '{2, 2, 3};
  logic [28:0]      spoil [4] = '{29'h400_0000, 29'h020_0000, 29'h002_0000, 29'h000_0000};
  rtcw_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_timer_ctrl_wr(wr_v[0]), .i_timer_ctrl(i_timer_ctrl),
    .i_first_reload_wr(wr_v[1]), .i_second_reload_wr(wr_v[2]), .i_reload_data(i_reload_data), .i_pattern(i_pattern),
    .i_one_hertz_tick(i_one_hertz_tick), .i_date_time_preset_wr(wr_v[3]), .i_date_time_preset(i_date_time_preset),
    .i_year_preset_wr(wr_v[4]), .i_year_preset(i_year_preset), .i_date_time_alarm(i_date_time_alarm),
    .i_year_alarm(i_year_alarm), .i_irq_clear_wr(wr_v[5]), .i_irq_clear(i_irq_clear), .i_irq_mask(i_irq_mask),
    .o_timer_count_value(o_timer_count_value), .o_first_reload_value(o_first_reload_value),
    .o_second_reload_value(o_second_reload_value), .o_timer_run_enable(o_timer_run_enable),
    .o_pattern_index(o_pattern_index), .o_date_time_count(o_date_time_count), .o_year_count(o_year_count),
    .o_raw_irq_status(o_raw_irq_status), .o_masked_irq_status(o_masked_irq_status), .o_combined_irq(o_combined_irq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic rtcw_date_s d(logic [3:0] m, logic [4:0] md, logic [2:0] wd, logic [4:0] h, logic [5:0] mi,
                                   logic [5:0] s);
    return {m, md, wd, h, mi, s};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  // One strobe per call; the trailing edge keeps strobes from merging
  task automatic pulse(input int w, input logic [31:0] v);
    @(posedge i_ref_clk);
    case (w)
      0: i_timer_ctrl <= v[9:0];
      3: i_date_time_preset <= v[28:0];
      4: i_year_preset <= v[12:0];
      5: i_irq_clear <= v[1:0];
      default: i_reload_data <= v;
    endcase
    wr_v <= 6'h1 << w;
    @(posedge i_ref_clk) wr_v <= 6'h0;
    cyc(1);
  endtask
  task automatic tick();
    @(posedge i_ref_clk) i_one_hertz_tick <= 1'b1;
    cyc(8);
    @(posedge i_ref_clk) i_one_hertz_tick <= 1'b0;
    cyc(8);
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (o_raw_irq_status[0] !== 1'b1) begin
      cyc(1);
      n++;
      if (n > lim) begin
        failures++;
        $display("MISMATCH t=%0t timer flag never came", $time);
        summarize();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst_n, wr_v, i_timer_ctrl, i_reload_data, i_one_hertz_tick, i_irq_clear} = '0;
    {i_date_time_preset, i_year_preset, i_date_time_alarm, i_year_alarm} = '0;
    i_pattern = {126'h0, 2'h2};
    i_irq_mask = 2'h1;
    failures = 0;
    checks = 0;
    rows[0] = '{d(4'h1, 5'h0F, 3'h3, 5'h0A, 6'h3B, 6'h3B), 13'h07E8, d(4'h1, 5'h0F, 3'h3, 5'h0B, 6'h0, 6'h0), 13'h07E8};
    rows[1] = '{d(4'h1, 5'h0F, 3'h7, 5'h17, 6'h3B, 6'h3B), 13'h07E8, d(4'h1, 5'h10, 3'h1, 5'h0, 6'h0, 6'h0), 13'h07E8};
    rows[2] = '{d(4'h4, 5'h1E, 3'h2, 5'h17, 6'h3B, 6'h3B), 13'h07E8, d(4'h5, 5'h01, 3'h3, 5'h0, 6'h0, 6'h0), 13'h07E8};
    rows[3] = '{d(4'h2, 5'h1C, 3'h3, 5'h17, 6'h3B, 6'h3B), 13'h07E7, d(4'h3, 5'h01, 3'h4, 5'h0, 6'h0, 6'h0), 13'h07E7};
    rows[4] = '{d(4'h2, 5'h1C, 3'h4, 5'h17, 6'h3B, 6'h3B), 13'h07E8, d(4'h2, 5'h1D, 3'h5, 5'h0, 6'h0, 6'h0), 13'h07E8};
    rows[5] = '{d(4'h2, 5'h1C, 3'h1, 5'h17, 6'h3B, 6'h3B), 13'h076C, d(4'h3, 5'h01, 3'h2, 5'h0, 6'h0, 6'h0), 13'h076C};
    rows[6] = '{d(4'h2, 5'h1C, 3'h2, 5'h17, 6'h3B, 6'h3B), 13'h07D0, d(4'h2, 5'h1D, 3'h3, 5'h0, 6'h0, 6'h0), 13'h07D0};
    rows[7] = '{d(4'hC, 5'h1F, 3'h3, 5'h17, 6'h3B, 6'h3B), 13'h07E8, d(4'h1, 5'h01, 3'h4, 5'h0, 6'h0, 6'h0), 13'h07E9};
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    cyc(1);
    cmp(o_timer_count_value, 32'hFFFF_FFFF, "reset count");
    cmp(32'({o_timer_run_enable, o_pattern_index, o_raw_irq_status}), 32'h0, "reset state");
    cmp(32'(o_date_time_count), 32'(d(4'h1, 5'h01, 3'h1, 5'h0, 6'h0, 6'h0)), "reset date");
    cmp(32'(o_year_count), 32'h0, "reset year");
    // Odd rows clear the calendar alarm fields and the year to test the wildcard match
    for (int i = 0; i < 8; i++) begin
      @(posedge i_ref_clk);
      i_date_time_alarm <= i[0] ? (rows[i].exp & 29'h001_FFFF) : rows[i].exp;
      i_year_alarm <= i[0] ? 13'h0 : rows[i].exp_y;
      pulse(4, 32'(rows[i].pre_y));
      pulse(3, 32'(rows[i].pre));
      tick();
      cmp(32'(o_date_time_count), 32'(rows[i].pre), "date load");
      cmp(32'({o_year_count, o_raw_irq_status}), 32'({rows[i].pre_y, 2'h0}), "year load");
      tick();
      cmp(32'(o_date_time_count), 32'(rows[i].exp), "date step");
      cmp(32'(o_year_count), 32'(rows[i].exp_y), "year step");
      cmp(32'({o_raw_irq_status, o_masked_irq_status, o_combined_irq}), 32'h10, "alarm");
      pulse(5, 32'h2);
      cmp(32'(o_raw_irq_status), 32'h0, "alarm clear");
    end
    // Each pass spoils one compared field of an otherwise matching alarm
    for (int j = 0; j < 4; j++) begin
      @(posedge i_ref_clk);
      i_date_time_alarm <= rows[0].exp ^ spoil[j];
      i_year_alarm <= rows[0].exp_y ^ 13'(j == 3);
      pulse(4, 32'(rows[0].pre_y));
      pulse(3, 32'(rows[0].pre));
      tick();
      tick();
      cmp(32'(o_raw_irq_status), 32'h0, "alarm mismatch");
    end
    pulse(1, 32'h1);
    pulse(2, 32'h2);
    cmp(o_timer_count_value, 32'h1, "halted reload");
    cmp(o_second_reload_value, 32'h2, "second reload");
    @(posedge i_ref_clk) i_irq_mask <= 2'h3;
    pulse(0, 32'h9);
    cmp(32'({o_timer_run_enable, o_pattern_index}), 32'h80, "periodic start");
    for (int k = 0; k < 3; k++) begin
      wait_irq(12000);
      cmp(32'(n > `RTCW_DECR_CYCLES * st[k] - 16 && n < `RTCW_DECR_CYCLES * st[k] + 4), 32'h1, "interval");
      cmp(o_timer_count_value, rl[k], "pattern reload");
      cmp(32'(o_pattern_index), ix[k], "pattern step");
      cmp(32'(o_combined_irq), 32'h1, "combined");
      if (k == 0) begin
        pulse(1, 32'h9);
        cmp(o_first_reload_value, 32'h1, "write while running");
      end
      if (k == 1) begin
        @(posedge i_ref_clk) i_irq_mask <= 2'h2;
        cyc(2);
        cmp(32'({o_raw_irq_status[0], o_masked_irq_status[0], o_combined_irq}), 32'h4, "masked");
        @(posedge i_ref_clk) i_irq_mask <= 2'h3;
      end
      pulse(5, 32'h1);
      cmp(32'(o_raw_irq_status), 32'h0, "timer clear");
    end
    pulse(0, 32'h8);
    pulse(0, 32'h20B);
    wait_irq(12000);
    cyc(2);
    cmp(32'({o_timer_count_value, o_timer_run_enable}), 32'h0, "one-shot halt");
    pulse(5, 32'h1);
    pulse(1, 32'h3);
    cmp(32'({o_timer_count_value, o_timer_run_enable}), 32'h7, "self start");
    pulse(0, 32'h00A);
    cmp(32'(o_timer_run_enable), 32'h0, "stopped");
    // Reset in mid-run must drop a running timer back to its idle state
    pulse(0, 32'h9);
    @(posedge i_ref_clk) i_rst_n <= 1'b0;
    @(posedge i_ref_clk) i_rst_n <= 1'b1;
    cyc(1);
    cmp(o_timer_count_value, 32'hFFFF_FFFF, "mid-run reset count");
    cmp(32'({o_timer_run_enable, o_pattern_index, o_raw_irq_status}), 32'h0, "mid-run reset state");
    summarize();
  end
endmodule
`default_nettype wire

/* File: design/rtcw_top.sv */
// Interval timer with two-value reload pattern and calendar clock watch with alarm
`timescale 1ns/1ps
`default_nettype none
`include "rtcw_cfg.svh"

module rtcw_top (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_timer_ctrl_wr,
  input  wire rtcw_pkg::rtcw_timer_ctrl_s i_timer_ctrl,
  input  wire logic                       i_first_reload_wr,
  input  wire logic                       i_second_reload_wr,
  input  wire logic [31:0]                i_reload_data,
  input  wire logic [127:0]               i_pattern,
  input  wire logic                       i_one_hertz_tick,
  input  wire logic                       i_date_time_preset_wr,
  input  wire rtcw_pkg::rtcw_date_s       i_date_time_preset,
  input  wire logic                       i_year_preset_wr,
  input  wire rtcw_pkg::rtcw_year_t       i_year_preset,
  input  wire rtcw_pkg::rtcw_date_s       i_date_time_alarm,
  input  wire rtcw_pkg::rtcw_year_t       i_year_alarm,
  input  wire logic                       i_irq_clear_wr,
  input  wire rtcw_pkg::rtcw_irq_t        i_irq_clear,
  input  wire rtcw_pkg::rtcw_irq_t        i_irq_mask,
  output logic [31:0]                     o_timer_count_value,
  output logic [31:0]                     o_first_reload_value,
  output logic [31:0]                     o_second_reload_value,
  output logic                            o_timer_run_enable,
  output logic [6:0]                      o_pattern_index,
  output rtcw_pkg::rtcw_date_s            o_date_time_count,
  output rtcw_pkg::rtcw_year_t            o_year_count,
  output rtcw_pkg::rtcw_irq_t             o_raw_irq_status,
  output rtcw_pkg::rtcw_irq_t             o_masked_irq_status,
  output logic                            o_combined_irq
);
  import rtcw_pkg::*;

  localparam logic [`RTCW_DECR_CNT_W-1:0] DECR_LAST = `RTCW_DECR_CNT_W'(`RTCW_DECR_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Timer state

  logic [`RTCW_DECR_CNT_W-1:0] decr_div_ff;
  logic                        decr_tick;
  logic [31:0]                 count_ff;
  logic [31:0]                 reload1_ff;
  logic [31:0]                 reload2_ff;
  logic                        run_ff;
  logic                        oneshot_ff;
  logic                        self_start_ff;
  logic [6:0]                  pat_len_ff;
  logic [6:0]                  pat_idx_ff;
  logic [6:0]                  nxt_pat_idx;
  logic [32:0]                 dec_full;
  logic                        timer_wrap;
  logic                        halted_wr;
  logic                        start_edge;

  // Prescaler from the fast clock down to the counter step rate
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      decr_div_ff <= '0;
    end else if (!run_ff || decr_div_ff == DECR_LAST) begin
      decr_div_ff <= '0;
    end else begin
      decr_div_ff <= decr_div_ff + `RTCW_DECR_CNT_W'(1);
    end
  end

  assign decr_tick  = run_ff && (decr_div_ff == DECR_LAST);
  assign dec_full   = {1'b0, count_ff} - 33'd1;
  // Carry out of the full width marks the pass through zero
  assign timer_wrap = decr_tick && dec_full[32];
  assign halted_wr  = !run_ff;
  assign start_edge = i_timer_ctrl_wr && i_timer_ctrl.timer_run_enable && !run_ff;

  always_comb begin
    nxt_pat_idx = pat_idx_ff + 7'd1;
    // A length of 0 or 1 keeps the timer on pattern bit 0
    if (nxt_pat_idx >= pat_len_ff) begin
      nxt_pat_idx = `RTCW_PAT_IDX_RST;
    end
  end

  // Control fields
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oneshot_ff    <= 1'b0;
      self_start_ff <= 1'b0;
      pat_len_ff    <= '0;
    end else if (i_timer_ctrl_wr) begin
      oneshot_ff    <= i_timer_ctrl.oneshot_select;
      self_start_ff <= i_timer_ctrl.self_start;
      pat_len_ff    <= i_timer_ctrl.pattern_len;
    end
  end

  // Run enable: software writes it, one-shot wrap and reload writes steer it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_ff <= 1'b0;
    end else if (i_timer_ctrl_wr) begin
      run_ff <= i_timer_ctrl.timer_run_enable;
    end else if (timer_wrap && oneshot_ff) begin
      run_ff <= 1'b0;
    end else if (halted_wr && self_start_ff && (i_first_reload_wr || i_second_reload_wr)) begin
      run_ff <= 1'b1;
    end
  end

  // Reload values only change while the counter stands
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload1_ff <= `RTCW_RELOAD_RST;
    end else if (i_first_reload_wr && halted_wr) begin
      reload1_ff <= i_reload_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload2_ff <= `RTCW_RELOAD_RST;
    end else if (i_second_reload_wr && halted_wr) begin
      reload2_ff <= i_reload_data;
    end
  end

  // Down-counter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= `RTCW_COUNT_RST;
    end else if (start_edge) begin
      count_ff <= reload1_ff;
    end else if (i_first_reload_wr && halted_wr) begin
      count_ff <= i_reload_data;
    end else if (timer_wrap) begin
      if (oneshot_ff) begin
        count_ff <= '0;
      end else if (i_pattern[pat_idx_ff]) begin
        count_ff <= reload2_ff;
      end else begin
        count_ff <= reload1_ff;
      end
    end else if (decr_tick) begin
      count_ff <= dec_full[31:0];
    end
  end

  // Pattern position restarts when a control write starts the counter from standstill; a self-start by reload write keeps it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pat_idx_ff <= `RTCW_PAT_IDX_RST;
    end else if (start_edge) begin
      pat_idx_ff <= `RTCW_PAT_IDX_RST;
    end else if (timer_wrap && !oneshot_ff) begin
      pat_idx_ff <= nxt_pat_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock watch

  logic       tick_meta_ff;
  logic       tick_sync_ff;
  logic       tick_prev_ff;
  logic       sec_tick;
  logic       preset_pend_ff;
  rtcw_date_s preset_date_ff;
  rtcw_year_t preset_year_ff;
  rtcw_date_s date_ff;
  rtcw_year_t year_ff;
  rtcw_date_s nxt_date;
  rtcw_year_t nxt_year;
  logic [4:0] mday_last;
  logic       leap;
  logic       alarm_hit;

  // The tick comes from another domain: two flops before the edge detector
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_meta_ff <= 1'b0;
      tick_sync_ff <= 1'b0;
      tick_prev_ff <= 1'b0;
    end else begin
      tick_meta_ff <= i_one_hertz_tick;
      tick_sync_ff <= tick_meta_ff;
      tick_prev_ff <= tick_sync_ff;
    end
  end

  assign sec_tick = tick_sync_ff && !tick_prev_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preset_date_ff <= '0;
    end else if (i_date_time_preset_wr) begin
      preset_date_ff <= i_date_time_preset;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preset_year_ff <= '0;
    end else if (i_year_preset_wr) begin
      preset_year_ff <= i_year_preset;
    end
  end

  // A preset write in the tick cycle waits for the following tick
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preset_pend_ff <= 1'b0;
    end else if (i_date_time_preset_wr) begin
      preset_pend_ff <= 1'b1;
    end else if (sec_tick) begin
      preset_pend_ff <= 1'b0;
    end
  end

  // Full Gregorian leap rule; out-of-range fields are not guarded
  assign leap = (year_ff[1:0] == 2'b00) &&
                ((year_ff % `RTCW_YEAR_C100) != '0 || (year_ff % `RTCW_YEAR_C400) == '0);

  always_comb begin
    case (date_ff.month)
      `RTCW_MONTH_FEB: mday_last = leap ? `RTCW_MDAY_29 : `RTCW_MDAY_28;
      `RTCW_MONTH_APR,
      `RTCW_MONTH_JUN,
      `RTCW_MONTH_SEP,
      `RTCW_MONTH_NOV: mday_last = `RTCW_MDAY_30;
      default:         mday_last = `RTCW_MDAY_31;
    endcase
  end

  // Ripple of carries from seconds up to year
  always_comb begin
    nxt_date = date_ff;
    nxt_year = year_ff;
    if (date_ff.second != `RTCW_SEC_MAX) begin
      nxt_date.second = date_ff.second + 6'd1;
    end else begin
      nxt_date.second = '0;
      if (date_ff.minute != `RTCW_MIN_MAX) begin
        nxt_date.minute = date_ff.minute + 6'd1;
      end else begin
        nxt_date.minute = '0;
        if (date_ff.hour != `RTCW_HOUR_MAX) begin
          nxt_date.hour = date_ff.hour + 5'd1;
        end else begin
          nxt_date.hour = '0;
          nxt_date.weekday = (date_ff.weekday == `RTCW_WDAY_LAST) ? `RTCW_WDAY_FIRST
                                                                   : date_ff.weekday + 3'd1;
          if (date_ff.monthday != mday_last) begin
            nxt_date.monthday = date_ff.monthday + 5'd1;
          end else begin
            nxt_date.monthday = `RTCW_MDAY_FIRST;
            if (date_ff.month != `RTCW_MONTH_LAST) begin
              nxt_date.month = date_ff.month + 4'd1;
            end else begin
              nxt_date.month = `RTCW_MONTH_FIRST;
              nxt_year       = year_ff + 13'd1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      date_ff         <= '0;
      date_ff.weekday <= `RTCW_WDAY_FIRST;
      date_ff.monthday <= `RTCW_MDAY_FIRST;
      date_ff.month   <= `RTCW_MONTH_FIRST;
      year_ff         <= `RTCW_YEAR_RST;
    end else if (sec_tick && preset_pend_ff) begin
      date_ff <= preset_date_ff;
      year_ff <= preset_year_ff;
    end else if (sec_tick) begin
      date_ff <= nxt_date;
      year_ff <= nxt_year;
    end
  end

  // Compare the incremented values so the alarm lands with the new time
  always_comb begin
    alarm_hit = (nxt_date.second == i_date_time_alarm.second) &&
                (i_date_time_alarm.second <= `RTCW_SEC_MAX) &&
                (nxt_date.minute == i_date_time_alarm.minute) &&
                (i_date_time_alarm.minute <= `RTCW_MIN_MAX) &&
                (nxt_date.hour == i_date_time_alarm.hour) &&
                (i_date_time_alarm.hour <= `RTCW_HOUR_MAX);
    if (i_date_time_alarm.month != '0 && i_date_time_alarm.month != nxt_date.month) begin
      alarm_hit = 1'b0;
    end
    if (i_date_time_alarm.monthday != '0 && i_date_time_alarm.monthday != nxt_date.monthday) begin
      alarm_hit = 1'b0;
    end
    if (i_date_time_alarm.weekday != '0 && i_date_time_alarm.weekday != nxt_date.weekday) begin
      alarm_hit = 1'b0;
    end
    if (i_year_alarm != '0 && i_year_alarm != nxt_year) begin
      alarm_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  rtcw_irq_t raw_ff;
  rtcw_irq_t irq_set;
  rtcw_irq_t irq_clr;
  rtcw_irq_t nxt_raw;

  always_comb begin
    irq_set = '0;
    irq_set[`RTCW_IRQ_TIMER] = timer_wrap;
    irq_set[`RTCW_IRQ_ALARM] = sec_tick && !preset_pend_ff && alarm_hit;
    irq_clr = i_irq_clear_wr ? i_irq_clear : '0;
    // A new event beats a clear in the same cycle
    nxt_raw = (raw_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw_ff              <= '0;
      o_masked_irq_status <= '0;
      o_combined_irq      <= 1'b0;
    end else begin
      raw_ff              <= nxt_raw;
      o_masked_irq_status <= nxt_raw & i_irq_mask;
      o_combined_irq      <= |(nxt_raw & i_irq_mask);
    end
  end

  assign o_raw_irq_status      = raw_ff;
  assign o_timer_count_value   = count_ff;
  assign o_first_reload_value  = reload1_ff;
  assign o_second_reload_value = reload2_ff;
  assign o_timer_run_enable    = run_ff;
  assign o_pattern_index       = pat_idx_ff;
  assign o_date_time_count     = date_ff;
  assign o_year_count          = year_ff;

endmodule

`default_nettype wire

/* File: inc/rtcw_cfg.svh */
// Timing counts, limits and reset values of the timer and clock watch block
`ifndef RTCW_CFG_SVH
`define RTCW_CFG_SVH

`define RTCW_CLK_PERIOD_PS      10_000
`define RTCW_DECR_PERIOD_PS     31_250_000
`define RTCW_DECR_CYCLES        (`RTCW_DECR_PERIOD_PS / `RTCW_CLK_PERIOD_PS)
`define RTCW_DECR_CNT_W         12

`define RTCW_COUNT_RST          32'hFFFF_FFFF
`define RTCW_RELOAD_RST         32'h0000_0000
`define RTCW_PAT_IDX_RST        7'h00

`define RTCW_SEC_MAX            6'h3B
`define RTCW_MIN_MAX            6'h3B
`define RTCW_HOUR_MAX           5'h17
`define RTCW_WDAY_FIRST         3'h1
`define RTCW_WDAY_LAST          3'h7
`define RTCW_MDAY_FIRST         5'h01
`define RTCW_MONTH_FIRST        4'h1
`define RTCW_MONTH_LAST         4'hC
`define RTCW_MONTH_FEB          4'h2
`define RTCW_MONTH_APR          4'h4
`define RTCW_MONTH_JUN          4'h6
`define RTCW_MONTH_SEP          4'h9
`define RTCW_MONTH_NOV          4'hB
`define RTCW_MDAY_31            5'h1F
`define RTCW_MDAY_30            5'h1E
`define RTCW_MDAY_29            5'h1D
`define RTCW_MDAY_28            5'h1C
`define RTCW_YEAR_RST           13'h0000
`define RTCW_YEAR_C100          13'h0064
`define RTCW_YEAR_C400          13'h0190

`define RTCW_IRQ_TIMER          0
`define RTCW_IRQ_ALARM          1

`endif

/* File: inc/rtcw_pkg.sv */
// Types shared by the timer and clock watch block
package rtcw_pkg;

  typedef struct packed {
    logic [3:0] month;
    logic [4:0] monthday;
    logic [2:0] weekday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcw_date_s;

  typedef struct packed {
    logic       self_start;
    logic [6:0] pattern_len;
    logic       oneshot_select;
    logic       timer_run_enable;
  } rtcw_timer_ctrl_s;

  typedef logic [12:0] rtcw_year_t;
  typedef logic [1:0]  rtcw_irq_t;

endpackage
